// File: iosrd_decoder.sv
// Notes on behaviour
// [R01] Software writes zero into unused bit positions.
// [R02] Unused bits need not read zero; here zero.
// [R03] Software never writes unassigned I/O addresses.
// [R04] Bit set/clear only on I/O 0x00-0x1F.
// [R05] Skip operations test one bit, set or clear.
// [R06] Flags clear on written one, zero keeps.
// [R07] Bit operations read-modify-write the whole register.
// [R08] Short-form transfers use I/O address, 64 locations.
// [R09] Data-space access adds 0x20 to I/O address.
// [R10] Extended range reached only by load/store.
// [R11] Unassigned addresses: writes ignored, reads zero.
module iosrd_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Core request
  input wire logic req_valid,
  input wire iosrd_pkg::iosrd_op_t req_op,
  input wire logic [8:0] req_addr,
  input wire logic [2:0] req_bit,
  input wire logic [7:0] req_wdata,
  // Core answer
  output logic req_busy,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_skip,
  output logic rsp_refused,
  // Port pins
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_dir,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_dir,
  output logic [7:0] port_d_out,
  output logic [7:0] port_d_dir,
  // Peripheral events and status
  input wire logic [7:0] timer8_evt,
  input wire logic [7:0] timer16_evt,
  input wire logic [7:0] ext_irq_evt,
  input wire logic cmp_evt,
  input wire logic cmp_level,
  input wire logic pll_locked,
  input wire logic [1:0] spi_status,
  // Extended data space
  output logic ext_rd,
  output logic ext_wr,
  output logic [8:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata
);

  logic [7:0] store_q [iosrd_pkg::IO_LOCS];
  logic [23:0] pin_s1_q;
  logic [23:0] pin_s2_q;
  logic [23:0] pin_s3_q;
  logic [23:0] pin_v_q;
  logic rsp_valid_q;
  logic [7:0] rsp_rdata_q;
  logic rsp_skip_q;
  logic rsp_refused_q;
  logic ext_rd_q;
  logic ext_wr_q;
  logic [8:0] ext_addr_q;
  logic [7:0] ext_wdata_q;
  logic [7:0] flag_val [iosrd_pkg::FLAG_REGS];
  logic [7:0] flag_evt [iosrd_pkg::FLAG_REGS];
  logic [7:0] flag_sel;

  // Operation classes.
  wire logic is_short = req_op == iosrd_pkg::io_input_op || req_op == iosrd_pkg::io_output_op;
  wire logic is_set = req_op == iosrd_pkg::set_single_bit_op;
  wire logic is_clr = req_op == iosrd_pkg::clear_single_bit_op;
  wire logic is_bitop = is_set || is_clr;
  wire logic is_skip = req_op == iosrd_pkg::skip_if_io_bit_set ||
                       req_op == iosrd_pkg::skip_if_io_bit_clear;
  wire logic is_load = req_op == iosrd_pkg::data_load_op;
  wire logic is_store = req_op == iosrd_pkg::data_store_op;
  wire logic is_data = is_load || is_store;
  wire logic wants_write = req_op == iosrd_pkg::io_output_op || is_bitop || is_store;

  // Address decoding per access class.
  wire logic in_io_data = req_addr >= iosrd_pkg::DATA_IO_OFFSET &&
                          req_addr <= iosrd_pkg::DATA_IO_HI;
  wire logic in_ext = req_addr >= iosrd_pkg::EXT_LO && req_addr <= iosrd_pkg::EXT_HI;
  wire logic [8:0] io_off = req_addr - iosrd_pkg::DATA_IO_OFFSET;
  wire logic [5:0] io_a = is_data ? io_off[5:0] : req_addr[5:0]; // R09 R08
  wire logic legal = is_short ? req_addr <= iosrd_pkg::SHORT_TOP : // R08
                     (is_bitop || is_skip) ? req_addr <= iosrd_pkg::BIT_TOP : // R04 R05
                     in_io_data || in_ext; // R10
  wire logic to_ext = is_data && in_ext; // R10
  wire logic to_io = legal && !to_ext;
  wire logic take = req_valid && !ext_rd_q;

  // Masks of the addressed register.
  wire logic [7:0] cur_rw = iosrd_pkg::rw_mask(io_a);
  wire logic [7:0] cur_live = iosrd_pkg::live_mask(io_a);
  wire logic [7:0] cur_w1c = iosrd_pkg::w1c_mask(io_a);
  wire logic assigned = (cur_rw | cur_live | cur_w1c) != 8'h00;

  // Hardware-driven bits. Status inputs come from logic on this clock and are not resynced.
  wire logic [7:0] pll_bits = {7'h00, pll_locked} << iosrd_pkg::PLL_LOCK_BIT;
  wire logic [7:0] spi_bits = {6'h00, spi_status} << iosrd_pkg::SPI_STAT_LSB;
  wire logic [7:0] cmp_bits = {7'h00, cmp_level} << iosrd_pkg::CMP_OUT_BIT;
  wire logic [7:0] live_val = io_a == iosrd_pkg::A_PORT_B_PIN ? pin_v_q[7:0] :
                              io_a == iosrd_pkg::A_PORT_C_PIN ? pin_v_q[15:8] :
                              io_a == iosrd_pkg::A_PORT_D_PIN ? pin_v_q[23:16] :
                              io_a == iosrd_pkg::A_PLL_CTRL_STAT ? pll_bits :
                              io_a == iosrd_pkg::A_SPI_STATUS ? spi_bits :
                              io_a == iosrd_pkg::A_CMP_CTRL_STAT ? cmp_bits : 8'h00;

  // Unused and unassigned positions read as zero since every mask excludes them.
  wire logic [7:0] rd_io = (store_q[io_a] & cur_rw) | (live_val & cur_live) | // R02 R11
                           (flag_sel & cur_w1c);

  // Bit operations rewrite the whole register, so set flags are written back as ones and clear.
  wire logic [7:0] bit_mask = 8'h01 << req_bit;
  wire logic [7:0] wr_val = is_set ? (rd_io | bit_mask) : // R07
                            is_clr ? (rd_io & ~bit_mask) : req_wdata; // R07
  wire logic io_wr = take && to_io && assigned && wants_write; // R11 R03
  wire logic refuse = take && (!legal || (to_io && !assigned && wants_write)); // R04 R03
  wire logic skip_match = rd_io[req_bit] == (req_op == iosrd_pkg::skip_if_io_bit_set); // R05
  wire logic answer_now = take && !(to_ext && is_load);
  wire logic [7:0] rd_answer = take && legal && !to_ext && !wants_write ? rd_io : 8'h00;

  always_comb begin
    flag_sel = 8'h00;
    for (int i = 0; i < iosrd_pkg::FLAG_REGS; i++) begin
      if (io_a == iosrd_pkg::FLAG_ADDR[i]) begin
        flag_sel = flag_val[i];
      end
    end
  end

  assign flag_evt[0] = timer8_evt;
  assign flag_evt[1] = timer16_evt;
  assign flag_evt[2] = ext_irq_evt;
  assign flag_evt[3] = {7'h00, cmp_evt} << iosrd_pkg::CMP_FLAG_BIT;

  // One flag register per event source; a written one clears, a zero leaves it.
  for (genvar g = 0; g < iosrd_pkg::FLAG_REGS; g++) begin : g_flags
    iosrd_flag_if flag_if ();
    assign flag_if.set = flag_evt[g];
    assign flag_if.clr = io_wr && io_a == iosrd_pkg::FLAG_ADDR[g] ? wr_val : 8'h00; // R06
    assign flag_val[g] = flag_if.value;
    iosrd_flag_reg #(
      .W1C_MASK(iosrd_pkg::FLAG_W1C[g])
    ) u_flag (
      .mclk(mclk),
      .rst(rst),
      .fl(flag_if.owner)
    );
  end

  // Plain register storage; only writable bit positions ever change.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < iosrd_pkg::IO_LOCS; i++) begin
        store_q[i] <= iosrd_pkg::RESET_VAL;
      end
    end else if (io_wr) begin
      store_q[io_a] <= (store_q[io_a] & ~cur_rw) | (wr_val & cur_rw); // R07
    end
  end

  // Pin inputs cross from outside; a new level counts once two stages agree.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_q <= 24'h000000;
      pin_s2_q <= 24'h000000;
      pin_s3_q <= 24'h000000;
      pin_v_q <= 24'h000000;
    end else begin
      pin_s1_q <= {pin_d, pin_c, pin_b};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_v_q <= (pin_s2_q & pin_s3_q) | (pin_v_q & (pin_s2_q | pin_s3_q));
    end
  end

  // Answers come one cycle after the request; extended loads take one more.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
      rsp_skip_q <= 1'b0;
      rsp_refused_q <= 1'b0;
    end else begin
      rsp_valid_q <= answer_now || ext_rd_q;
      rsp_rdata_q <= ext_rd_q ? ext_rdata : rd_answer;
      rsp_skip_q <= take && is_skip && legal && skip_match; // R05
      rsp_refused_q <= refuse;
    end
  end

  // Extended data space is handed on only for load and store forms.
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= 9'h000;
      ext_wdata_q <= 8'h00;
    end else begin
      ext_rd_q <= take && to_ext && is_load; // R10
      ext_wr_q <= take && to_ext && is_store; // R10
      ext_addr_q <= take && to_ext ? req_addr : ext_addr_q;
      ext_wdata_q <= take && to_ext ? req_wdata : ext_wdata_q;
    end
  end

  assign req_busy = ext_rd_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_skip = rsp_skip_q;
  assign rsp_refused = rsp_refused_q;
  assign ext_rd = ext_rd_q;
  assign ext_wr = ext_wr_q;
  assign ext_addr = ext_addr_q;
  assign ext_wdata = ext_wdata_q;
  assign port_b_out = store_q[iosrd_pkg::A_PORT_B_OUT];
  assign port_b_dir = store_q[iosrd_pkg::A_PORT_B_DIR];
  assign port_c_out = store_q[iosrd_pkg::A_PORT_C_OUT];
  assign port_c_dir = store_q[iosrd_pkg::A_PORT_C_DIR];
  assign port_d_out = store_q[iosrd_pkg::A_PORT_D_OUT];
  assign port_d_dir = store_q[iosrd_pkg::A_PORT_D_DIR];

  // Checks.
  wire logic [7:0] ext_flags = flag_val[2];
  wire logic pb_bit = port_b_out[req_bit];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_bitop_high;
    take && is_bitop && req_addr > iosrd_pkg::BIT_TOP;
  endsequence
  sequence s_short_high;
    take && is_short && req_addr > iosrd_pkg::SHORT_TOP;
  endsequence
  sequence s_skip_port_b;
    take && req_op == iosrd_pkg::skip_if_io_bit_set && req_addr == {3'h0, iosrd_pkg::A_PORT_B_OUT};
  endsequence
  sequence s_ext_flag_write;
    io_wr && is_store && io_a == iosrd_pkg::A_EXT_IRQ_FLAGS;
  endsequence
  sequence s_ext_flag_set_op;
    io_wr && is_set && io_a == iosrd_pkg::A_EXT_IRQ_FLAGS;
  endsequence

  chk_bitop_range_refused: assert property (s_bitop_high |-> !io_wr ##1 rsp_refused) // R04
    else $error("bit operation above bit range not refused");
  chk_skip_port_bit: assert property (s_skip_port_b |=> rsp_valid && rsp_skip == $past(pb_bit)) // R05
    else $error("skip answer does not match tested bit");
  chk_w1c_one_clears: assert property (s_ext_flag_write |=> // R06
    (ext_flags & $past(wr_val) & ~$past(ext_irq_evt)) == 8'h00)
    else $error("flag not cleared by written one");
  chk_w1c_zero_keeps: assert property (s_ext_flag_write |=> // R06
    ($past(ext_flags) & ~$past(wr_val) & ~ext_flags) == 8'h00)
    else $error("flag changed by written zero");
  chk_rmw_clears_flags: assert property (s_ext_flag_set_op |=> // R07
    (ext_flags & ~$past(ext_irq_evt)) == 8'h00)
    else $error("bit set did not clear pending flags");
  chk_short_range: assert property (s_short_high |-> !io_wr ##1 rsp_refused && !ext_wr) // R08
    else $error("short-form access above 64 locations accepted");
  chk_data_alias: assert property (take && is_store && // R09
    req_addr == iosrd_pkg::DATA_IO_OFFSET + {3'h0, iosrd_pkg::A_PORT_B_OUT} |=>
    port_b_out == $past(req_wdata))
    else $error("data-space store missed aliased register");
  chk_ext_reach: assert property (take && to_ext |=> (ext_rd || ext_wr) && // R10
    ext_addr == $past(req_addr))
    else $error("extended access not forwarded");
  chk_ext_only_data: assert property (take && !is_data |=> !ext_rd && !ext_wr) // R10
    else $error("non load/store reached extended range");
  chk_unassigned_zero: assert property (take && is_load && in_io_data && !assigned |=> // R11
    rsp_valid && rsp_rdata == 8'h00 ##1 $stable(port_b_out))
    else $error("unassigned read not zero");

endmodule : iosrd_decoder

// File: iosrd_pkg.sv
package iosrd_pkg;

  // Operation classes presented by the core; the three load forms and the three
  // store forms share one class each because they decode identically.
  typedef enum logic [2:0] {
    io_input_op = 3'h0,
    io_output_op = 3'h1,
    set_single_bit_op = 3'h2,
    clear_single_bit_op = 3'h3,
    skip_if_io_bit_set = 3'h4,
    skip_if_io_bit_clear = 3'h5,
    data_load_op = 3'h6,
    data_store_op = 3'h7
  } iosrd_op_t;

  localparam int IO_LOCS = 64;
  localparam int FLAG_REGS = 4;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // Address ranges in the core's address spaces.
  localparam logic [8:0] BIT_TOP = 9'h01f;
  localparam logic [8:0] SHORT_TOP = 9'h03f;
  localparam logic [8:0] DATA_IO_OFFSET = 9'h020;
  localparam logic [8:0] DATA_IO_HI = 9'h05f;
  localparam logic [8:0] EXT_LO = 9'h060;
  localparam logic [8:0] EXT_HI = 9'h1ff;

  // I/O addresses of the register map.
  localparam logic [5:0] A_PORT_B_PIN = 6'h03;
  localparam logic [5:0] A_PORT_B_DIR = 6'h04;
  localparam logic [5:0] A_PORT_B_OUT = 6'h05;
  localparam logic [5:0] A_PORT_C_PIN = 6'h06;
  localparam logic [5:0] A_PORT_C_DIR = 6'h07;
  localparam logic [5:0] A_PORT_C_OUT = 6'h08;
  localparam logic [5:0] A_PORT_D_PIN = 6'h09;
  localparam logic [5:0] A_PORT_D_DIR = 6'h0a;
  localparam logic [5:0] A_PORT_D_OUT = 6'h0b;
  localparam logic [5:0] A_TIMER8_FLAGS = 6'h15;
  localparam logic [5:0] A_TIMER16_FLAGS = 6'h16;
  localparam logic [5:0] A_EXT_IRQ_FLAGS = 6'h1c;
  localparam logic [5:0] A_EXT_IRQ_MASK = 6'h1d;
  localparam logic [5:0] A_SCRATCH_ZERO = 6'h1e;
  localparam logic [5:0] A_NV_DATA_CTRL = 6'h1f;
  localparam logic [5:0] A_TIMER8_CTRL_B = 6'h25;
  localparam logic [5:0] A_TIMER8_COUNT = 6'h26;
  localparam logic [5:0] A_TIMER8_CMP_A = 6'h27;
  localparam logic [5:0] A_TIMER8_CMP_B = 6'h28;
  localparam logic [5:0] A_PLL_CTRL_STAT = 6'h29;
  localparam logic [5:0] A_SCRATCH_ONE = 6'h2a;
  localparam logic [5:0] A_SCRATCH_TWO = 6'h2b;
  localparam logic [5:0] A_SPI_CTRL = 6'h2c;
  localparam logic [5:0] A_SPI_STATUS = 6'h2d;
  localparam logic [5:0] A_SPI_DATA = 6'h2e;
  localparam logic [5:0] A_CMP_CTRL_STAT = 6'h30;
  localparam logic [5:0] A_ONEWIRE_DATA = 6'h31;

  // Field layouts: writable bits, hardware-driven bits and write-one-to-clear bits.
  localparam logic [7:0] M_FULL = 8'hff;
  localparam logic [7:0] M_NONE = 8'h00;
  localparam logic [7:0] M_PORT_C = 8'hf7;
  localparam logic [7:0] M_NV_CTRL = 8'h3f;
  localparam logic [7:0] M_T8_CTRL_B = 8'h0f;
  localparam logic [7:0] M_PLL_RW = 8'h1e;
  localparam logic [7:0] M_PLL_LIVE = 8'h01;
  localparam logic [7:0] M_SPI_RW = 8'h01;
  localparam logic [7:0] M_SPI_LIVE = 8'hc0;
  localparam logic [7:0] M_CMP_RW = 8'hcf;
  localparam logic [7:0] M_CMP_LIVE = 8'h20;
  localparam logic [7:0] W_TIMER8 = 8'h07;
  localparam logic [7:0] W_TIMER16 = 8'h2f;
  localparam logic [7:0] W_EXT_IRQ = 8'hff;
  localparam logic [7:0] W_CMP = 8'h10;
  localparam int PLL_LOCK_BIT = 0;
  localparam int SPI_STAT_LSB = 6;
  localparam int CMP_OUT_BIT = 5;
  localparam int CMP_FLAG_BIT = 4;

  localparam logic [5:0] FLAG_ADDR [FLAG_REGS] = '{A_TIMER8_FLAGS, A_TIMER16_FLAGS,
                                                   A_EXT_IRQ_FLAGS, A_CMP_CTRL_STAT};
  localparam logic [7:0] FLAG_W1C [FLAG_REGS] = '{W_TIMER8, W_TIMER16, W_EXT_IRQ, W_CMP};

  function automatic logic [7:0] rw_mask(input logic [5:0] a);
    logic [7:0] m;
    m = M_NONE;
    if (a == A_PORT_B_DIR || a == A_PORT_B_OUT || a == A_PORT_D_DIR || a == A_PORT_D_OUT) begin
      m = M_FULL;
    end else if (a == A_PORT_C_DIR || a == A_PORT_C_OUT) begin
      m = M_PORT_C;
    end else if (a == A_EXT_IRQ_MASK || a == A_SCRATCH_ZERO || a == A_SCRATCH_ONE) begin
      m = M_FULL;
    end else if (a == A_SCRATCH_TWO || a == A_SPI_CTRL || a == A_SPI_DATA) begin
      m = M_FULL;
    end else if (a == A_TIMER8_COUNT || a == A_TIMER8_CMP_A || a == A_TIMER8_CMP_B) begin
      m = M_FULL;
    end else if (a == A_ONEWIRE_DATA) begin
      m = M_FULL;
    end else if (a == A_NV_DATA_CTRL) begin
      m = M_NV_CTRL;
    end else if (a == A_TIMER8_CTRL_B) begin
      m = M_T8_CTRL_B;
    end else if (a == A_PLL_CTRL_STAT) begin
      m = M_PLL_RW;
    end else if (a == A_SPI_STATUS) begin
      m = M_SPI_RW;
    end else if (a == A_CMP_CTRL_STAT) begin
      m = M_CMP_RW;
    end
    return m;
  endfunction : rw_mask

  function automatic logic [7:0] live_mask(input logic [5:0] a);
    logic [7:0] m;
    m = M_NONE;
    if (a == A_PORT_B_PIN || a == A_PORT_D_PIN) begin
      m = M_FULL;
    end else if (a == A_PORT_C_PIN) begin
      m = M_PORT_C;
    end else if (a == A_PLL_CTRL_STAT) begin
      m = M_PLL_LIVE;
    end else if (a == A_SPI_STATUS) begin
      m = M_SPI_LIVE;
    end else if (a == A_CMP_CTRL_STAT) begin
      m = M_CMP_LIVE;
    end
    return m;
  endfunction : live_mask

  function automatic logic [7:0] w1c_mask(input logic [5:0] a);
    logic [7:0] m;
    m = M_NONE;
    for (int i = 0; i < FLAG_REGS; i++) begin
      if (a == FLAG_ADDR[i]) begin
        m = FLAG_W1C[i];
      end
    end
    return m;
  endfunction : w1c_mask

endpackage : iosrd_pkg

// File: iosrd_flag_if.sv
interface iosrd_flag_if;
  logic [7:0] set;
  logic [7:0] clr;
  logic [7:0] value;
  modport owner (input set, input clr, output value);
  modport user (output set, output clr, input value);
endinterface : iosrd_flag_if

// File: iosrd_flag_reg.sv
module iosrd_flag_reg #(
  parameter logic [7:0] W1C_MASK = 8'hff
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Flag set and clear
  iosrd_flag_if.owner fl
);

  logic [7:0] flags_q;

  // A hardware event in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= iosrd_pkg::RESET_VAL;
    end else begin
      flags_q <= ((flags_q & ~fl.clr) | fl.set) & W1C_MASK; // R06
    end
  end

  assign fl.value = flags_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_set_wins_clear: assert property ((fl.set & W1C_MASK) != 8'h00 |=> // R06
    (flags_q & $past(fl.set) & W1C_MASK) == ($past(fl.set) & W1C_MASK))
    else $error("flag event lost against a clearing write");

endmodule : iosrd_flag_reg

// File: iosrd_ext_mem.sv
module iosrd_ext_mem (
  // Clock
  input wire logic mclk,
  // Extended data space access
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [8:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [512];
  logic [7:0] last_q = 8'h00;
  wire logic [7:0] rd_now = mem_q[ext_addr];
  // Outside a read cycle the bus toggles, so a sample one cycle late sees the read data inverted.
  assign ext_rdata = ext_rd ? rd_now : ~last_q;
  always @(posedge mclk) begin
    if (ext_wr) mem_q[ext_addr] <= ext_wdata;
    if (ext_rd) last_q <= rd_now;
    else last_q <= ~last_q;
  end
endmodule : iosrd_ext_mem

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  iosrd_pkg::iosrd_op_t req_op = iosrd_pkg::io_input_op;
  logic [8:0] req_addr = 9'h000;
  logic [2:0] req_bit = 3'h0;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] pin_b = 8'h00, pin_c = 8'h00, pin_d = 8'h00;
  logic [7:0] timer8_evt = 8'h00, timer16_evt = 8'h00, ext_irq_evt = 8'h00;
  logic cmp_evt = 1'b0, cmp_level = 1'b0, pll_locked = 1'b0;
  logic [1:0] spi_status = 2'h0;
  logic req_busy, rsp_valid, rsp_skip, rsp_refused, ext_rd, ext_wr;
  logic [7:0] rsp_rdata, port_b_out, port_b_dir, port_c_out, port_c_dir, port_d_out, port_d_dir;
  logic [7:0] ext_wdata, ext_rdata, wd, g_data;
  logic [8:0] ext_addr;
  logic g_skip, g_ref, g_busy;
  logic [7:0] mdl [64];
  int fails = 0;
  int n_tests = 0;
  int seed = 14;
  int cyc = 0;
  iosrd_pkg::iosrd_op_t rop [7] = '{iosrd_pkg::set_single_bit_op,
    iosrd_pkg::skip_if_io_bit_clear, iosrd_pkg::io_input_op, iosrd_pkg::io_output_op,
    iosrd_pkg::data_load_op, iosrd_pkg::io_output_op, iosrd_pkg::data_store_op};
  logic [8:0] radr [7] = '{9'h020, 9'h03f, 9'h040, 9'h060, 9'h01f, 9'h000, 9'h02c};

  always #20 mclk = ~mclk;

  iosrd_decoder u_iosrd_decoder (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
    .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
    .rsp_refused(rsp_refused), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d),
    .port_b_out(port_b_out), .port_b_dir(port_b_dir), .port_c_out(port_c_out),
    .port_c_dir(port_c_dir), .port_d_out(port_d_out), .port_d_dir(port_d_dir),
    .timer8_evt(timer8_evt), .timer16_evt(timer16_evt), .ext_irq_evt(ext_irq_evt),
    .cmp_evt(cmp_evt), .cmp_level(cmp_level), .pll_locked(pll_locked),
    .spi_status(spi_status), .ext_rd(ext_rd), .ext_wr(ext_wr), .ext_addr(ext_addr),
    .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  iosrd_ext_mem u_iosrd_ext_mem (.mclk(mclk), .ext_rd(ext_rd), .ext_wr(ext_wr),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

  function automatic logic [7:0] wmask(input int a);
    case (a)
      4, 5, 10, 11, 29, 30, 38, 39, 40, 42, 43, 44, 46, 49: return 8'hff;
      7, 8: return 8'hf7;
      31: return 8'h3f;
      37: return 8'h0f;
      41: return 8'h1e;
      45: return 8'h01;
      48: return 8'hcf;
      default: return 8'h00;
    endcase
  endfunction : wmask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  // The request is held through its taking edge; the answer is read mid-cycle.
  task automatic xfer(input iosrd_pkg::iosrd_op_t op, input logic [8:0] a,
                      input logic [2:0] b, input logic [7:0] d);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_bit <= b;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    @(negedge mclk);
    g_busy = req_busy;
    for (int i = 0; i < 3 && rsp_valid !== 1'b1; i++) @(negedge mclk);
    chk_flag(rsp_valid, 1'b1);
    g_data = rsp_rdata;
    g_skip = rsp_skip;
    g_ref = rsp_refused;
  endtask : xfer

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    for (int i = 0; i < 64; i++) mdl[i] = 8'h00;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_data(port_b_out | port_b_dir | port_c_out | port_c_dir | port_d_out | port_d_dir, 8'h00);
    // Alternate the short form and the data-space alias on writes and read-backs.
    for (int i = 0; i < 64; i++) begin
      if (wmask(i) != 8'h00) begin
        wd = 8'($random(seed)) & wmask(i);
        if (i[0]) xfer(iosrd_pkg::data_store_op, 9'(i) + 9'h020, 3'h0, wd);
        else xfer(iosrd_pkg::io_output_op, 9'(i), 3'h0, wd);
        mdl[i] = wd;
        chk_flag(g_ref, 1'b0);
        if (i[0]) xfer(iosrd_pkg::io_input_op, 9'(i), 3'h0, 8'h00);
        else xfer(iosrd_pkg::data_load_op, 9'(i) + 9'h020, 3'h0, 8'h00);
        chk_data(g_data, mdl[i]);
      end
    end
    chk_data(port_c_out, mdl[8]);
    chk_data(port_d_dir, mdl[10]);
    chk_data(port_b_dir, mdl[4]);
    chk_data(port_b_out, mdl[5]);
    chk_data(port_c_dir, mdl[7]);
    chk_data(port_d_out, mdl[11]);
    pin_b <= 8'($random(seed));
    pin_c <= 8'($random(seed));
    pin_d <= 8'($random(seed));
    pll_locked <= 1'b1;
    spi_status <= 2'h2;
    cmp_level <= 1'b1;
    repeat (6) @(posedge mclk);
    xfer(iosrd_pkg::io_input_op, 9'h003, 3'h0, 8'h00);
    chk_data(g_data, pin_b);
    xfer(iosrd_pkg::data_load_op, 9'h026, 3'h0, 8'h00);
    chk_data(g_data, pin_c & 8'hf7);
    xfer(iosrd_pkg::data_load_op, 9'h029, 3'h0, 8'h00);
    chk_data(g_data, pin_d);
    xfer(iosrd_pkg::io_input_op, 9'h029, 3'h0, 8'h00);
    chk_data(g_data, mdl[41] | 8'h01);
    xfer(iosrd_pkg::io_input_op, 9'h02d, 3'h0, 8'h00);
    chk_data(g_data, mdl[45] | 8'h80);
    for (int i = 0; i < 8; i++) begin
      xfer(i[0] ? iosrd_pkg::set_single_bit_op : iosrd_pkg::clear_single_bit_op,
           9'h005, 3'(i), 8'h00);
      mdl[5][i] = i[0];
      chk_data(port_b_out, mdl[5]);
      xfer(iosrd_pkg::skip_if_io_bit_set, 9'h005, 3'(i), 8'h00);
      chk_flag(g_skip, mdl[5][i]);
      xfer(iosrd_pkg::skip_if_io_bit_clear, 9'h005, 3'((i + 3) % 8), 8'h00);
      chk_flag(g_skip, !mdl[5][(i + 3) % 8]);
    end
    xfer(iosrd_pkg::set_single_bit_op, 9'h01f, 3'h0, 8'h00);
    mdl[31][0] = 1'b1;
    xfer(iosrd_pkg::io_input_op, 9'h01f, 3'h0, 8'h00);
    chk_data(g_data, mdl[31]);
    @(posedge mclk);
    timer8_evt <= 8'hff;
    timer16_evt <= 8'hff;
    ext_irq_evt <= 8'h25;
    cmp_evt <= 1'b1;
    @(posedge mclk);
    timer8_evt <= 8'h00;
    timer16_evt <= 8'h00;
    ext_irq_evt <= 8'h00;
    cmp_evt <= 1'b0;
    xfer(iosrd_pkg::io_input_op, 9'h016, 3'h0, 8'h00);
    chk_data(g_data, 8'h2f);
    xfer(iosrd_pkg::io_output_op, 9'h015, 3'h0, 8'h00);
    xfer(iosrd_pkg::io_input_op, 9'h015, 3'h0, 8'h00);
    chk_data(g_data, 8'h07);
    xfer(iosrd_pkg::io_output_op, 9'h015, 3'h0, 8'h02);
    xfer(iosrd_pkg::io_input_op, 9'h015, 3'h0, 8'h00);
    chk_data(g_data, 8'h05);
    xfer(iosrd_pkg::data_store_op, 9'h03c, 3'h0, 8'h01);
    xfer(iosrd_pkg::io_input_op, 9'h01c, 3'h0, 8'h00);
    chk_data(g_data, 8'h24);
    xfer(iosrd_pkg::clear_single_bit_op, 9'h01c, 3'h2, 8'h00);
    xfer(iosrd_pkg::io_input_op, 9'h01c, 3'h0, 8'h00);
    chk_data(g_data, 8'h04);
    xfer(iosrd_pkg::set_single_bit_op, 9'h01c, 3'h0, 8'h00);
    xfer(iosrd_pkg::io_input_op, 9'h01c, 3'h0, 8'h00);
    chk_data(g_data, 8'h00);
    xfer(iosrd_pkg::io_input_op, 9'h030, 3'h0, 8'h00);
    chk_data(g_data, mdl[48] | 8'h30);
    xfer(iosrd_pkg::io_output_op, 9'h030, 3'h0, mdl[48] | 8'h10);
    xfer(iosrd_pkg::io_input_op, 9'h030, 3'h0, 8'h00);
    chk_data(g_data, mdl[48] | 8'h20);
    for (int i = 0; i < 7; i++) begin
      xfer(rop[i], radr[i], 3'h0, 8'h01);
      chk_flag(g_ref, 1'b1);
    end
    xfer(iosrd_pkg::io_input_op, 9'h002, 3'h0, 8'h00);
    chk_data(g_data, 8'h00);
    chk_flag(g_ref, 1'b0);
    xfer(iosrd_pkg::data_load_op, 9'h022, 3'h0, 8'h00);
    chk_data(g_data, 8'h00);
    chk_flag(g_ref, 1'b0);
    wd = 8'($random(seed));
    xfer(iosrd_pkg::data_store_op, 9'h1ff, 3'h0, wd);
    chk_flag(g_ref, 1'b0);
    xfer(iosrd_pkg::data_store_op, 9'h060, 3'h0, ~wd);
    xfer(iosrd_pkg::data_load_op, 9'h1ff, 3'h0, 8'h00);
    chk_flag(g_busy, 1'b1);
    chk_data(g_data, wd);
    xfer(iosrd_pkg::data_load_op, 9'h060, 3'h0, 8'h00);
    chk_data(g_data, ~wd);
    report_and_stop();
  end
endmodule : tb_top
